/* File: common/tda_pkg.sv */
// Package for the test DAC / ADC register bank.
// Assumes a 32-bit AXI4-Lite bus with 12-bit byte addresses.
package tda_pkg;

  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_DAC_ONE  = 8'h39;
  localparam logic [7:0] IDX_DAC_TWO  = 8'h3A;
  localparam logic [7:0] IDX_ADC      = 8'h3B;
  localparam logic [7:0] IDX_PT_A     = 8'h3C;
  localparam logic [7:0] IDX_PT_B     = 8'h3D;
  localparam logic [7:0] IDX_PT_C     = 8'h3E;
  localparam logic [7:0] IDX_PT_D     = 8'h3F;
  localparam logic [7:0] IDX_ROUTE    = 8'h40;

  localparam logic [AXI_AW-1:0] ADDR_DAC_ONE = {2'h0, IDX_DAC_ONE, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_DAC_TWO = {2'h0, IDX_DAC_TWO, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_ADC     = {2'h0, IDX_ADC, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_PT_A    = {2'h0, IDX_PT_A, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_PT_B    = {2'h0, IDX_PT_B, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_PT_C    = {2'h0, IDX_PT_C, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_PT_D    = {2'h0, IDX_PT_D, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_ROUTE   = {2'h0, IDX_ROUTE, 2'h0};

  // Field layout
  localparam int DAC_W      = 6;
  localparam int ADC_W      = 4;
  localparam int SEL_W      = 4;
  localparam int ADC_I_LSB  = 4;
  localparam int ADC_Q_LSB  = 0;
  localparam int SEL_ONE_LSB = 4;
  localparam int SEL_TWO_LSB = 0;

  // Reset values
  localparam logic [7:0] RST_DAC   = 8'h00;
  localparam logic [7:0] RST_PT_A  = 8'hFF;
  localparam logic [7:0] RST_PT_B  = 8'h00;
  localparam logic [7:0] RST_PT_C  = 8'h03;
  localparam logic [7:0] RST_PT_D  = 8'h00;
  localparam logic [7:0] RST_ROUTE = 8'h00;

  // Auxiliary pin selector patterns
  localparam logic [SEL_W-1:0] SEL_TRISTATE = 4'h0;
  localparam logic [SEL_W-1:0] SEL_DAC      = 4'h1;
  localparam logic [SEL_W-1:0] SEL_HIGH     = 4'hA;
  localparam logic [SEL_W-1:0] SEL_LOW      = 4'hB;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } tda_wr_state_e;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } tda_rd_state_e;

  // What one auxiliary pin does
  typedef struct packed {
    logic             dac_route;
    logic             drive_en;
    logic             level;
    logic [SEL_W-1:0] sel;
  } tda_aux_s;

endpackage

/* File: src/tda_sync.sv */
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit settles between samples; bits are not coherent.
`timescale 1ns/1ps
module tda_sync #(
  parameter int W = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage_one;
  logic [W-1:0] next_stage_one;
  logic [W-1:0] next_sync_out;

  always_comb begin
    next_stage_one = async_in;
    next_sync_out  = stage_one;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= next_stage_one;
      sync_out  <= next_sync_out;
    end
  end

endmodule // tda_sync

/* File: src/tda_aux_route.sv */
// Decodes one auxiliary pin selector into pin controls.
// Assumes the selector comes from a register on the same clock.
`timescale 1ns/1ps
module tda_aux_route
  import tda_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [SEL_W-1:0] sel,
  output tda_aux_s              aux
);

  tda_aux_s next_aux;

  always_comb begin
    next_aux           = '0;
    next_aux.sel       = sel;
    // Test DAC current output onto the pin
    next_aux.dac_route = (sel == SEL_DAC);
    if (sel == SEL_HIGH) begin
      next_aux.drive_en = 1'b1;
      next_aux.level    = 1'b1;
    end else if (sel == SEL_LOW) begin
      next_aux.drive_en = 1'b1;
    end else if (sel != SEL_TRISTATE) begin
      // Analog or internal test signal: pin is driven by that source
      next_aux.drive_en = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux <= '0;
    end else begin
      aux <= next_aux;
    end
  end

endmodule // tda_aux_route

/* File: src/tda_register_bank.sv */
// Test DAC / ADC register bank with production-test registers.
// Assumes an AXI4-Lite master on aclk and ADC samples from the analog
// domain, which are synchronised here.
// Unmapped byte addresses answer DECERR and change nothing.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tda_register_bank
  import tda_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0] s_axil_awaddr,
  input  wire logic [2:0]        s_axil_awprot,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [AXI_DW-1:0] s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [AXI_AW-1:0] s_axil_araddr,
  input  wire logic [2:0]        s_axil_arprot,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output logic [AXI_DW-1:0]      s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  // Analog side
  input  wire logic [ADC_W-1:0]  adc_i_sample,
  input  wire logic [ADC_W-1:0]  adc_q_sample,
  output logic [DAC_W-1:0]       first_dac_code,
  output logic [DAC_W-1:0]       second_dac_code,
  output tda_aux_s               first_auxiliary_pin,
  output tda_aux_s               second_auxiliary_pin
);

  // Register state
  logic [7:0]          first_dac_value_register;
  logic [7:0]          second_dac_value_register;
  logic [7:0]          analog_routing_register;
  logic [7:0]          next_first_dac;
  logic [7:0]          next_second_dac;
  logic [7:0]          next_routing;

  // Write channel state
  tda_wr_state_e       wr_state;
  tda_wr_state_e       next_wr_state;
  logic                aw_held;
  logic                next_aw_held;
  logic                w_held;
  logic                next_w_held;
  logic [AXI_AW-1:0]   wr_addr;
  logic [AXI_AW-1:0]   next_wr_addr;
  logic [7:0]          wr_byte;
  logic [7:0]          next_wr_byte;
  logic                wr_lane;
  logic                next_wr_lane;
  logic [1:0]          bresp;
  logic [1:0]          next_bresp;

  // Read channel state
  tda_rd_state_e       rd_state;
  tda_rd_state_e       next_rd_state;
  logic [AXI_DW-1:0]   rdata;
  logic [AXI_DW-1:0]   next_rdata;
  logic [1:0]          rresp;
  logic [1:0]          next_rresp;

  // Synchronised ADC samples
  logic [2*ADC_W-1:0]  adc_sync;
  logic [7:0]          adc_sample_register;

  logic                aw_fire;
  logic                w_fire;
  logic                ar_fire;

  // Protection bits and upper byte lanes carry nothing for byte registers
  logic                unused_bits;
  assign unused_bits = ^{s_axil_awprot, s_axil_arprot,
                         s_axil_wdata[AXI_DW-1:8], s_axil_wstrb[3:1]};

  // ADC samples come from another domain: two flops before use
  // Bits of one sample are not coherent; a settled sample reads clean
  tda_sync #(
    .W (2*ADC_W)
  ) u_adc_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({adc_i_sample, adc_q_sample}),
    .sync_out (adc_sync)
  );

  always_comb begin
    adc_sample_register = '0;
    adc_sample_register[ADC_I_LSB +: ADC_W] =
      adc_sync[ADC_W +: ADC_W];
    adc_sample_register[ADC_Q_LSB +: ADC_W] =
      adc_sync[0 +: ADC_W];
  end

  // Handshakes
  // One write and one read may be in flight at the same time
  assign s_axil_awready = (wr_state == WR_COLLECT) && !aw_held;
  assign s_axil_wready  = (wr_state == WR_COLLECT) && !w_held;
  assign s_axil_bvalid  = (wr_state == WR_RESP);
  assign s_axil_bresp   = bresp;
  assign s_axil_arready = (rd_state == RD_IDLE);
  assign s_axil_rvalid  = (rd_state == RD_DATA);
  assign s_axil_rdata   = rdata;
  assign s_axil_rresp   = rresp;

  assign aw_fire = s_axil_awvalid && s_axil_awready;
  assign w_fire  = s_axil_wvalid && s_axil_wready;
  assign ar_fire = s_axil_arvalid && s_axil_arready;

  // Write path: address and data are taken in either order, the
  // register is updated once both are held, then the response follows.
  always_comb begin
    next_wr_state   = wr_state;
    next_aw_held    = aw_held;
    next_w_held     = w_held;
    next_wr_addr    = wr_addr;
    next_wr_byte    = wr_byte;
    next_wr_lane    = wr_lane;
    next_bresp      = bresp;
    next_first_dac  = first_dac_value_register;
    next_second_dac = second_dac_value_register;
    next_routing    = analog_routing_register;
    case (wr_state)
      WR_COLLECT: begin
        if (aw_fire) begin
          next_aw_held = 1'b1;
          next_wr_addr = s_axil_awaddr;
        end
        if (w_fire) begin
          next_w_held  = 1'b1;
          next_wr_byte = s_axil_wdata[7:0];
          next_wr_lane = s_axil_wstrb[0];
        end
        if (aw_held && w_held) begin
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = WR_RESP;
          next_bresp    = RESP_OKAY;
          if (wr_addr == ADDR_DAC_ONE) begin
            if (wr_lane) begin
              // Upper two bits stay zero
              next_first_dac = {2'h0, wr_byte[DAC_W-1:0]};
            end
          end else if (wr_addr == ADDR_DAC_TWO) begin
            if (wr_lane) begin
              next_second_dac = {2'h0, wr_byte[DAC_W-1:0]};
            end
          end else if (wr_addr == ADDR_ROUTE) begin
            // First pin selector in bits 7..4, second in bits 3..0
            if (wr_lane) begin
              next_routing = wr_byte;
            end
          end else if (wr_addr == ADDR_ADC || wr_addr == ADDR_PT_A ||
                       wr_addr == ADDR_PT_B || wr_addr == ADDR_PT_C ||
                       wr_addr == ADDR_PT_D) begin
            // Accepted and dropped: read-only and reserved contents
            next_bresp = RESP_OKAY;
          end else begin
            // Unmapped: refused, no register changes
            next_bresp = RESP_DECERR;
          end
        end
      end
      WR_RESP: begin
        if (s_axil_bready) begin
          next_wr_state = WR_COLLECT;
        end
      end
      default: begin
        next_wr_state = WR_COLLECT;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state                  <= WR_COLLECT;
      aw_held                   <= 1'b0;
      w_held                    <= 1'b0;
      wr_addr                   <= '0;
      wr_byte                   <= '0;
      wr_lane                   <= 1'b0;
      bresp                     <= RESP_OKAY;
      // Value bits are undefined after reset; zero is chosen
      first_dac_value_register  <= RST_DAC;
      second_dac_value_register <= RST_DAC;
      analog_routing_register   <= RST_ROUTE;
    end else begin
      wr_state                  <= next_wr_state;
      aw_held                   <= next_aw_held;
      w_held                    <= next_w_held;
      wr_addr                   <= next_wr_addr;
      wr_byte                   <= next_wr_byte;
      wr_lane                   <= next_wr_lane;
      bresp                     <= next_bresp;
      first_dac_value_register  <= next_first_dac;
      second_dac_value_register <= next_second_dac;
      analog_routing_register   <= next_routing;
    end
  end

  // Read path: data is captured when the address is taken
  always_comb begin
    next_rd_state = rd_state;
    next_rdata    = rdata;
    next_rresp    = rresp;
    case (rd_state)
      RD_IDLE: begin
        if (ar_fire) begin
          next_rd_state = RD_DATA;
          next_rresp    = RESP_OKAY;
          next_rdata    = '0;
          // Production registers are fixed at their reset values
          if (s_axil_araddr == ADDR_DAC_ONE) begin
            next_rdata[7:0] = first_dac_value_register;
          end else if (s_axil_araddr == ADDR_DAC_TWO) begin
            next_rdata[7:0] = second_dac_value_register;
          end else if (s_axil_araddr == ADDR_ADC) begin
            next_rdata[7:0] = adc_sample_register;
          end else if (s_axil_araddr == ADDR_PT_A) begin
            next_rdata[7:0] = RST_PT_A;
          end else if (s_axil_araddr == ADDR_PT_B) begin
            next_rdata[7:0] = RST_PT_B;
          end else if (s_axil_araddr == ADDR_PT_C) begin
            next_rdata[7:0] = RST_PT_C;
          end else if (s_axil_araddr == ADDR_PT_D) begin
            next_rdata[7:0] = RST_PT_D;
          end else if (s_axil_araddr == ADDR_ROUTE) begin
            next_rdata[7:0] = analog_routing_register;
          end else begin
            next_rresp = RESP_DECERR;
          end
        end
      end
      RD_DATA: begin
        if (s_axil_rready) begin
          next_rd_state = RD_IDLE;
        end
      end
      default: begin
        next_rd_state = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      rdata    <= '0;
      rresp    <= RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rdata    <= next_rdata;
      rresp    <= next_rresp;
    end
  end

  // DAC codes straight from the value registers
  assign first_dac_code  = first_dac_value_register[DAC_W-1:0];
  assign second_dac_code = second_dac_value_register[DAC_W-1:0];

  // Auxiliary pin control, one decoder per pin
  logic [SEL_W-1:0]    aux_sel [2];
  tda_aux_s            aux_pin [2];

  assign aux_sel[0] = analog_routing_register[SEL_ONE_LSB +: SEL_W];
  assign aux_sel[1] = analog_routing_register[SEL_TWO_LSB +: SEL_W];

  for (genvar g = 0; g < 2; g++) begin : g_aux
    tda_aux_route u_aux (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sel     (aux_sel[g]),
      .aux     (aux_pin[g])
    );
  end

  assign first_auxiliary_pin  = aux_pin[0];
  assign second_auxiliary_pin = aux_pin[1];

endmodule // tda_register_bank

/* File: verification/tda_checker.sv */
// Port assertions for the test DAC / ADC register bank.
// Assumes it is bound to tda_register_bank and sees only its ports.
`timescale 1ns/1ps
module tda_checker
  import tda_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axil_bvalid,
  input wire logic [AXI_AW-1:0] s_axil_araddr,
  input wire logic              s_axil_arvalid,
  input wire logic              s_axil_arready,
  input wire logic [AXI_DW-1:0] s_axil_rdata,
  input wire logic [1:0]        s_axil_rresp,
  input wire logic [ADC_W-1:0]  adc_i_sample,
  input wire logic [ADC_W-1:0]  adc_q_sample,
  input wire logic [DAC_W-1:0]  first_dac_code,
  input wire logic [DAC_W-1:0]  second_dac_code,
  input wire tda_aux_s          first_auxiliary_pin,
  input wire tda_aux_s          second_auxiliary_pin
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire              ar_f = s_axil_arvalid && s_axil_arready;
  wire [AXI_AW-1:0] ra   = s_axil_araddr;
  wire [AXI_DW-1:0] rdat = s_axil_rdata;

  a_dac_one_hold: assert property (
    !$rose(s_axil_bvalid) |-> $stable(first_dac_code))
    else $error("first DAC code moved without a write");
  a_dac_two_hold: assert property (
    !$rose(s_axil_bvalid) |-> $stable(second_dac_code))
    else $error("second DAC code moved without a write");
  a_aux_one_dac: assert property (
    first_auxiliary_pin.dac_route == (first_auxiliary_pin.sel == SEL_DAC))
    else $error("first aux DAC routing wrong");
  a_aux_two_dac: assert property (
    second_auxiliary_pin.dac_route == (second_auxiliary_pin.sel == SEL_DAC))
    else $error("second aux DAC routing wrong");
  a_dac_upper_zero: assert property (
    ar_f && (ra == ADDR_DAC_ONE || ra == ADDR_DAC_TWO) |=> rdat[7:6] == 2'b00)
    else $error("DAC upper bits not zero");
  a_adc_live: assert property (
    ($stable(adc_i_sample) && $stable(adc_q_sample))[*3] ##0
    (ar_f && ra == ADDR_ADC) |=>
    rdat == {24'h000000, $past(adc_i_sample), $past(adc_q_sample)})
    else $error("ADC read does not show the samples");
  a_pt_a_ones: assert property (
    ar_f && ra == ADDR_PT_A |=> rdat == 32'h000000FF)
    else $error("production register A wrong");
  a_pt_bd_zero: assert property (
    ar_f && (ra == ADDR_PT_B || ra == ADDR_PT_D) |=> rdat == 32'h00000000)
    else $error("production register B or D wrong");
  a_pt_c_three: assert property (
    ar_f && ra == ADDR_PT_C |=> rdat == 32'h00000003)
    else $error("production register C wrong");
  a_unmapped_err: assert property (
    ar_f && ra < ADDR_DAC_ONE |=> s_axil_rresp == RESP_DECERR)
    else $error("unmapped read not refused");

  c_adc_read: cover property (ar_f && ra == ADDR_ADC);
  c_decerr: cover property (ar_f && ra < ADDR_DAC_ONE);
  c_dac_route: cover property ($rose(first_auxiliary_pin.dac_route));
endmodule // tda_checker

bind tda_register_bank tda_checker chk_u (
  .aclk, .aresetn, .s_axil_bvalid, .s_axil_araddr, .s_axil_arvalid,
  .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .adc_i_sample,
  .adc_q_sample, .first_dac_code, .second_dac_code, .first_auxiliary_pin,
  .second_auxiliary_pin
);

/* File: verification/tb.sv */
// Self-checking bench for the test DAC / ADC register bank.
// Assumes the bank alone on one 125 MHz clock, driven over AXI4-Lite.
`timescale 1ns/1ps
module tb
  import tda_pkg::*;
;
  logic              aclk = 0, aresetn = 0;
  logic [AXI_AW-1:0] s_axil_awaddr = 0, s_axil_araddr = 0;
  logic [AXI_DW-1:0] s_axil_wdata = 0, s_axil_rdata;
  logic [3:0]        s_axil_wstrb = 0;
  logic              s_axil_awvalid = 0, s_axil_wvalid = 0;
  logic              s_axil_bready = 0, s_axil_arvalid = 0;
  logic              s_axil_rready = 0, s_axil_awready, s_axil_wready;
  logic              s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [2:0]        s_axil_awprot = 0, s_axil_arprot = 0;
  logic [1:0]        s_axil_bresp, s_axil_rresp;
  logic [ADC_W-1:0]  adc_i_sample = 0, adc_q_sample = 0;
  logic [DAC_W-1:0]  first_dac_code, second_dac_code;
  tda_aux_s          first_auxiliary_pin, second_auxiliary_pin;
  logic [33:0]       qr[$], qb[$];
  int                n_errors = 0, n_tests = 0;
  logic [11:0]       pa[4] = '{ADDR_PT_A, ADDR_PT_B, ADDR_PT_C, ADDR_PT_D};
  logic [7:0]        pv[4] = '{8'hFF, 8'h00, 8'h03, 8'h00};
  logic [7:0]        d1, d2;
  wire  [33:0]       rs = {s_axil_rresp, s_axil_rdata};
  wire  [33:0]       bs = {s_axil_bresp, 32'h00000000};

  tda_register_bank dut_u (
    .aclk, .aresetn, .s_axil_awaddr, .s_axil_awprot, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid,
    .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_araddr, .s_axil_arprot, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .adc_i_sample, .adc_q_sample, .first_dac_code, .second_dac_code,
    .first_auxiliary_pin, .second_auxiliary_pin
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected pin controls for one selector pattern
  function automatic tda_aux_s aux_exp(input logic [SEL_W-1:0] s);
    aux_exp           = '0;
    aux_exp.dac_route = (s == SEL_DAC);
    aux_exp.drive_en  = (s != SEL_TRISTATE);
    aux_exp.level     = (s == SEL_HIGH);
    aux_exp.sel       = s;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic s, input logic [1:0] r);
    @(posedge aclk);
    qb.push_back({r, 32'h00000000});
    s_axil_awaddr  <= a;
    s_axil_wdata   <= {24'h000000, d};
    s_axil_wstrb   <= {3'h0, s};
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid  <= 1'b1;
    s_axil_bready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_bvalid) begin
        s_axil_bready <= 1'b0;
        return;
      end
    end
    n_errors++;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    @(posedge aclk);
    qr.push_back(e);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready  <= 1'b1;
    for (int k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      if (s_axil_rvalid) begin
        s_axil_rready <= 1'b0;
        return;
      end
    end
    n_errors++;
  endtask

  task automatic tally_and_finish();
    // Notes never answered count as mismatches
    n_errors += qr.size() + qb.size();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Scoreboard: each answer is matched against the oldest note
  always @(posedge aclk) begin
    if (s_axil_rvalid && s_axil_rready && qr.size() == 0) n_errors++;
    if (s_axil_bvalid && s_axil_bready && qb.size() == 0) n_errors++;
    if (s_axil_rvalid && s_axil_rready && qr.size() > 0)
      chk(rs, qr.pop_front());
    if (s_axil_bvalid && s_axil_bready && qb.size() > 0)
      chk(bs, qb.pop_front());
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(54436));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_DAC_ONE, {RESP_OKAY, 32'h00000000});
    rd(ADDR_DAC_TWO, {RESP_OKAY, 32'h00000000});
    // Constants hold before and after writes to them
    for (int p = 0; p < 2; p++) begin
      for (int j = 0; j < 4; j++) begin
        if (p == 1) wr(pa[j], 8'h5A, 1'b1, RESP_OKAY);
        rd(pa[j], {RESP_OKAY, 24'h000000, pv[j]});
      end
    end
    for (int j = 0; j < 8; j++) begin
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      wr(ADDR_DAC_ONE, d1, 1'b1, RESP_OKAY);
      wr(ADDR_DAC_TWO, d2, 1'b1, RESP_OKAY);
      chk({22'h0, first_dac_code, second_dac_code},
          {22'h0, d1[5:0], d2[5:0]});
      // Lane 0 strobe off must leave the value alone
      wr(ADDR_DAC_ONE, ~d1, 1'b0, RESP_OKAY);
      rd(ADDR_DAC_ONE, {RESP_OKAY, 26'h0, d1[5:0]});
      rd(ADDR_DAC_TWO, {RESP_OKAY, 26'h0, d2[5:0]});
    end
    for (int j = 0; j < 8; j++) begin
      adc_i_sample <= 4'($urandom);
      adc_q_sample <= 4'($urandom);
      repeat (3) @(posedge aclk);
      wr(ADDR_ADC, 8'hC3, 1'b1, RESP_OKAY);
      rd(ADDR_ADC, {RESP_OKAY, 24'h000000, adc_i_sample, adc_q_sample});
    end
    for (int s = 0; s < 16; s++) begin
      wr(ADDR_ROUTE, {4'(s), ~4'(s)}, 1'b1, RESP_OKAY);
      rd(ADDR_ROUTE, {RESP_OKAY, 24'h000000, 4'(s), ~4'(s)});
      chk({20'h0, first_auxiliary_pin, second_auxiliary_pin},
          {20'h0, aux_exp(4'(s)), aux_exp(~4'(s))});
    end
    wr(12'h000, 8'hFF, 1'b1, RESP_DECERR);
    rd(12'h000, {RESP_DECERR, 32'h00000000});
    rd(ADDR_DAC_ONE + 12'h001, {RESP_DECERR, 32'h00000000});
    // Reset in mid-run clears the DAC values again
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_DAC_ONE, {RESP_OKAY, 32'h00000000});
    rd(ADDR_DAC_TWO, {RESP_OKAY, 32'h00000000});
    repeat (2) @(posedge aclk);
    tally_and_finish();
  end
endmodule // tb
